// File: rtl/piso_pkg.sv
// constants shared by the parallel-load shift register block
package piso_pkg;
    localparam int STAGE_COUNT = 8;
    localparam logic [7:0] STAGE_RESET = 8'h00;
    localparam int FIFO_WIDTH = 8;
    localparam int FIFO_DEPTH = 16;
    localparam int FIFO_PTR_W = 4;
    localparam int FIFO_CNT_W = 5;
endpackage

// File: rtl/piso_shift_register_8bit.sv
// eight-stage parallel/serial-in serial-out shift register with input fifo
//
// Overview of operation
// - Eight stages form a chain, the first fed by serial or parallel data, the last driving the serial output.
// - With shift selected and clocking enabled, each effective edge shifts serial data into the first stage.
// - With load selected, the next effective edge captures the next queued eight-bit word, if one is waiting, and ignores serial data.
// - Apart from clear, stages change only on a rising edge of the NOR of the clock input and the inhibit input.
// - Either gating input held high freezes the stages; held low, the other input acts as clock.
// - A low clear forces all stages and the serial output to zero regardless of other inputs.
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////////
module piso_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16,
    parameter int PTR_W = 4,
    parameter int CNT_W = 5
) (
    // clock and reset
    input wire logic sys_clk_i,
    input wire logic rst_i,
    // fill side
    input wire logic in_valid_i,
    output logic in_ready_o,
    input wire logic [WIDTH-1:0] in_data_i,
    // drain side
    output logic out_valid_o,
    input wire logic out_ready_i,
    output logic [WIDTH-1:0] out_data_o
);
    logic [WIDTH-1:0] mem_reg [DEPTH];
    logic [PTR_W-1:0] wr_ptr_reg;
    logic [PTR_W-1:0] rd_ptr_reg;
    logic [CNT_W-1:0] count_reg;
    logic push;
    logic pop;

    assign in_ready_o = (count_reg != CNT_W'(DEPTH));
    assign out_valid_o = (count_reg != '0);
    assign push = in_valid_i && in_ready_o;
    assign pop = out_valid_o && out_ready_i;
    assign out_data_o = mem_reg[rd_ptr_reg];

    always_ff @(posedge sys_clk_i) begin
        if (push) begin
            mem_reg[wr_ptr_reg] <= in_data_i;
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
            count_reg <= '0;
        end else begin
            if (push) begin
                wr_ptr_reg <= wr_ptr_reg + PTR_W'(1);
            end
            if (pop) begin
                rd_ptr_reg <= rd_ptr_reg + PTR_W'(1);
            end
            if (push && !pop) begin
                count_reg <= count_reg + CNT_W'(1);
            end else if (pop && !push) begin
                count_reg <= count_reg - CNT_W'(1);
            end
        end
    end
endmodule

////////////////////////////////////////////////////////////////////////////////
module piso_shift_register_8bit
    import piso_pkg::*;
(
    // clock and reset
    input wire logic sys_clk_i,
    input wire logic rst_i,
    // broadside words, queued ahead of the register
    input wire logic par_valid_i,
    output logic par_ready_o,
    input wire logic [7:0] par_data_i,
    // pins from the driving logic
    input wire logic shift_or_load_select_i,
    input wire logic serial_data_in_i,
    input wire logic clock_in_i,
    input wire logic clock_inhibit_i,
    input wire logic clear_n_i,
    // serial result
    output logic last_stage_serial_out_o,
    output logic first_stage_value_o
);
    logic [1:0] sel_sync_reg;
    logic [1:0] ser_sync_reg;
    logic [1:0] clk_sync_reg;
    logic [1:0] inh_sync_reg;
    logic [1:0] clr_sync_reg;
    logic gate_prev_reg;
    logic [7:0] stage_reg;
    logic gated_clk;
    logic edge_hit;
    logic clear_act;
    logic fifo_valid;
    logic fifo_ready;
    logic [7:0] fifo_data;

    // pins are asynchronous to sys_clk; two flops each before use
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            sel_sync_reg <= 2'h0;
            ser_sync_reg <= 2'h0;
            clk_sync_reg <= 2'h0;
            inh_sync_reg <= 2'h3;
            clr_sync_reg <= 2'h0;
        end else begin
            sel_sync_reg <= {sel_sync_reg[0], shift_or_load_select_i};
            ser_sync_reg <= {ser_sync_reg[0], serial_data_in_i};
            clk_sync_reg <= {clk_sync_reg[0], clock_in_i};
            inh_sync_reg <= {inh_sync_reg[0], clock_inhibit_i};
            clr_sync_reg <= {clr_sync_reg[0], clear_n_i};
        end
    end

    assign gated_clk = ~(clk_sync_reg[1] | inh_sync_reg[1]);
    assign clear_act = ~clr_sync_reg[1] | ~clear_n_i;

    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            gate_prev_reg <= 1'b1;
        end else begin
            gate_prev_reg <= gated_clk;
        end
    end

    // apart from clear, a rising edge of the NOR output is the only event that moves stages
    assign edge_hit = gated_clk && !gate_prev_reg;

    piso_fifo #(
        .WIDTH(FIFO_WIDTH),
        .DEPTH(FIFO_DEPTH),
        .PTR_W(FIFO_PTR_W),
        .CNT_W(FIFO_CNT_W)
    ) u_fifo (
        .sys_clk_i(sys_clk_i),
        .rst_i(rst_i),
        .in_valid_i(par_valid_i),
        .in_ready_o(par_ready_o),
        .in_data_i(par_data_i),
        .out_valid_o(fifo_valid),
        .out_ready_i(fifo_ready),
        .out_data_o(fifo_data)
    );

    // a load consumes one queued word; an empty queue leaves the stages as they are
    assign fifo_ready = edge_hit && !clear_act && !sel_sync_reg[1];

    // limitation: clear also uses the raw pin so it acts without waiting
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            stage_reg <= STAGE_RESET;
        end else if (clear_act) begin
            stage_reg <= STAGE_RESET;
        end else if (edge_hit) begin
            if (sel_sync_reg[1]) begin
                stage_reg <= {stage_reg[6:0], ser_sync_reg[1]};
            end else if (fifo_valid) begin
                stage_reg <= fifo_data;
            end
        end
    end

    // output is masked combinationally so clear reaches it at once
    assign last_stage_serial_out_o = stage_reg[STAGE_COUNT-1] & clear_n_i;
    assign first_stage_value_o = stage_reg[0] & clear_n_i;

    ////////////////////////////////////////////////////////////////////////////
    clear_zeroes_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        !clear_n_i |=> stage_reg == 8'h00)
        else $error("clear did not zero stages");
    out_clear_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        !clear_n_i |-> !last_stage_serial_out_o)
        else $error("serial out high during clear");
    shift_move_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        edge_hit && !clear_act && sel_sync_reg[1]
        |=> stage_reg == {$past(stage_reg[6:0]), $past(ser_sync_reg[1])})
        else $error("shift did not advance");
    load_take_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        edge_hit && !clear_act && !sel_sync_reg[1] && fifo_valid
        |=> stage_reg == $past(fifo_data))
        else $error("load did not capture word");
    empty_hold_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        edge_hit && !clear_act && !sel_sync_reg[1] && !fifo_valid |=> $stable(stage_reg))
        else $error("load from empty queue changed stages");
    hold_noedge_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        !edge_hit && !clear_act |=> $stable(stage_reg))
        else $error("stages moved without edge");
    nor_edge_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        edge_hit |-> !clk_sync_reg[1] && !inh_sync_reg[1]
            && $past(clk_sync_reg[1] | inh_sync_reg[1]))
        else $error("edge without rising gated clock");
    inhibit_hold_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        inh_sync_reg[1] && !clear_act |=> $stable(stage_reg))
        else $error("stages moved while inhibited");
    chain_end_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        clear_n_i |-> last_stage_serial_out_o == stage_reg[7])
        else $error("output not last stage");
    clear_first_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        edge_hit && clear_act |=> stage_reg == 8'h00)
        else $error("edge beat clear");

    shift_seen_c: cover property (@(posedge sys_clk_i) disable iff (rst_i)
        edge_hit && sel_sync_reg[1] && !clear_act);
    load_seen_c: cover property (@(posedge sys_clk_i) disable iff (rst_i)
        fifo_ready && fifo_valid);
    fifo_full_c: cover property (@(posedge sys_clk_i) disable iff (rst_i)
        !par_ready_o);
    inhibit_seen_c: cover property (@(posedge sys_clk_i) disable iff (rst_i)
        inh_sync_reg[1] && clk_sync_reg[1] == 1'b0);
    clear_edge_c: cover property (@(posedge sys_clk_i) disable iff (rst_i)
        edge_hit && clear_act);
endmodule

// File: dv/pin_source.sv
// model of the driving logic at the clock and inhibit pins
`timescale 1ns/1ps
module pin_source (
    // clock
    input wire logic sys_clk_i,
    // requests from the bench
    input wire logic step_i,
    input wire logic hold_i,
    // pins
    output logic clock_in_o,
    output logic clock_inhibit_o
);
    logic [3:0] low_reg = 4'h0;
    logic inhibit_reg = 1'b0;
    ////////////////////////////////////////////////////////////////////////////
    // clock pin idles high; a step gives one low phase of 8 cycles
    always_ff @(posedge sys_clk_i) begin
        if (step_i && low_reg == 4'h0) begin
            low_reg <= 4'h8;
        end else if (low_reg != 4'h0) begin
            low_reg <= low_reg - 4'h1;
        end
    end
    assign clock_in_o = (low_reg == 4'h0);
    // inhibit may drop at any time but rises only while the clock pin is high
    always_ff @(posedge sys_clk_i) begin
        if (!hold_i) begin
            inhibit_reg <= 1'b0;
        end else if (clock_in_o) begin
            inhibit_reg <= 1'b1;
        end
    end
    assign clock_inhibit_o = inhibit_reg;
endmodule

// File: dv/tb.sv
// self-checking bench for the eight-stage shift register
`timescale 1ns/1ps
module tb;
    import piso_pkg::*;
    logic sys_clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic par_valid_i = 1'b0;
    logic [7:0] par_data_i = 8'h00;
    logic shift_or_load_select_i = 1'b1;
    logic serial_data_in_i = 1'b0;
    logic clear_n_i = 1'b1;
    logic step_i = 1'b0;
    logic hold_i = 1'b0;
    logic clk_pin, inh_pin, par_ready_o, last_stage_serial_out_o, first_stage_value_o;
    int n_fail = 0;
    int n_tests = 0;
    always #12.5 sys_clk_i = ~sys_clk_i;
    piso_shift_register_8bit u_dut (.sys_clk_i, .rst_i, .par_valid_i, .par_ready_o,
        .par_data_i, .shift_or_load_select_i, .serial_data_in_i, .clock_in_i(clk_pin),
        .clock_inhibit_i(inh_pin), .clear_n_i, .last_stage_serial_out_o, .first_stage_value_o);
    pin_source u_pins (.sys_clk_i, .step_i, .hold_i, .clock_in_o(clk_pin),
        .clock_inhibit_o(inh_pin));
    ////////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [1:0] seen, input logic [1:0] exp);
        n_tests++;
        if (seen !== exp) begin
            n_fail++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic finish_test();
        $display("comparisons %0d mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk_i);
    endtask
    // one effective edge, then time for the two-flop sync and detect
    task automatic pulse();
        step_i <= 1'b1;
        tick(1);
        step_i <= 1'b0;
        tick(13);
    endtask
    function automatic logic [1:0] outs();
        return {last_stage_serial_out_o, first_stage_value_o};
    endfunction
    ////////////////////////////////////////////////////////////////////////////
    task automatic load_then_shift();
        logic [7:0] word = 8'ha5;
        par_data_i <= word;
        par_valid_i <= 1'b1;
        tick(1);
        par_valid_i <= 1'b0;
        shift_or_load_select_i <= 1'b0;
        tick(4);
        pulse();
        check(outs(), 2'b11);
        shift_or_load_select_i <= 1'b1;
        for (int k = 1; k < 8; k++) begin
            serial_data_in_i <= k[0];
            tick(4);
            pulse();
            check(outs(), {word[7 - k], k[0]});
        end
    endtask
    task automatic inhibit_and_clear();
        hold_i <= 1'b1;
        serial_data_in_i <= 1'b0;
        tick(6);
        pulse();
        check(outs(), 2'b11);
        // stages still hold data at mid-cycle, so only the pin can mask the output
        hold_i <= 1'b0;
        clear_n_i <= 1'b0;
        par_data_i <= 8'h81;
        par_valid_i <= 1'b1;
        @(negedge sys_clk_i);
        check(outs(), 2'b00);
        tick(1);
        par_valid_i <= 1'b0;
        shift_or_load_select_i <= 1'b0;
        pulse();
        check(outs(), 2'b00);
        clear_n_i <= 1'b1;
        tick(4);
        check(outs(), 2'b00);
        // the queued word survives only if clear overrode the load edge
        pulse();
        check(outs(), 2'b11);
    endtask
    // fill past depth, then drain one word per load edge
    task automatic fifo_fill_drain();
        par_valid_i <= 1'b1;
        for (int i = 0; i < 17; i++) begin
            par_data_i <= {i[0], 7'h00};
            tick(1);
        end
        check({1'b0, par_ready_o}, 2'b00);
        par_valid_i <= 1'b0;
        for (int i = 0; i < 17; i++) begin
            pulse();
            check(outs(), {(i > 15) | i[0], 1'b0});
        end
    endtask
    initial begin
        tick(5);
        rst_i <= 1'b0;
        tick(4);
        check(outs(), 2'b00);
        load_then_shift();
        inhibit_and_clear();
        fifo_fill_drain();
        finish_test();
    end
    initial begin
        tick(3000);
        n_fail++;
        finish_test();
    end
endmodule
